// ===== lmr_pkg.sv
// package for the literal, move and return execution block
// assumes a 14-bit instruction word and a 15-bit program counter
package lmr_pkg;
  localparam int INSN_W     = 14;
  localparam int PC_W       = 15;
  localparam int PTR_W      = 16;
  localparam int DATA_W     = 8;
  localparam int FADDR_W    = 7;
  localparam int BANK_W     = 5;
  localparam int LATCH_W    = 7;
  localparam int OFFS_W     = 6;
  localparam int GIE_BIT    = 7;
  localparam int RETI_CYC   = 2;
  localparam int SEL_BIT    = 2;
  localparam int MODE_W     = 2;

  localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
  localparam logic [DATA_W-1:0]  OPT_RST   = 8'hFF;
  localparam logic [DATA_W-1:0]  INTC_RST  = 8'h00;
  localparam logic [PTR_W-1:0]   PTR_RST   = 16'h0000;
  localparam logic [PTR_W-1:0]   PTR_ONE   = 16'h0001;
  localparam logic [PC_W-1:0]    PC_ONE    = 15'h0001;
  localparam logic [FADDR_W-1:0] IND0_ADDR = 7'h00;
  localparam logic [FADDR_W-1:0] IND1_ADDR = 7'h01;

  // opcode patterns, compared under a care mask
  localparam logic [INSN_W-1:0] OP_NOP   = 14'h0000;
  localparam logic [INSN_W-1:0] OP_RESET = 14'h0001;
  localparam logic [INSN_W-1:0] OP_RETI  = 14'h0009;
  localparam logic [INSN_W-1:0] OP_OPT   = 14'h0062;
  localparam logic [INSN_W-1:0] OP_STIW  = 14'h0018;
  localparam logic [INSN_W-1:0] OP_STF   = 14'h0080;
  localparam logic [INSN_W-1:0] OP_LDB   = 14'h0020;
  localparam logic [INSN_W-1:0] OP_STIK  = 14'h3F80;
  localparam logic [INSN_W-1:0] OP_LDP   = 14'h3180;
  localparam logic [INSN_W-1:0] OP_LDW   = 14'h3000;
  localparam logic [INSN_W-1:0] MSK_ALL  = 14'h3FFF;
  localparam logic [INSN_W-1:0] MSK_STIW = 14'h3FF8;
  localparam logic [INSN_W-1:0] MSK_F7   = 14'h3F80;
  localparam logic [INSN_W-1:0] MSK_B5   = 14'h3FE0;
  localparam logic [INSN_W-1:0] MSK_K7   = 14'h3F80;
  localparam logic [INSN_W-1:0] MSK_K8   = 14'h3C00;

  typedef enum logic [1:0] {
    MODE_PREINC  = 2'h0,
    MODE_PREDEC  = 2'h1,
    MODE_POSTINC = 2'h2,
    MODE_POSTDEC = 2'h3
  } lmr_mode_t;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_FLUSH = 3'b010,
    ST_RESET = 3'b100
  } lmr_state_t;

  // data memory write port
  typedef struct packed {
    logic               en;
    logic [PTR_W-1:0]   addr;
    logic [DATA_W-1:0]  data;
    logic               indirect;
  } lmr_wr_t;
endpackage

// ===== lmr_exec.sv
// execution of literal loads, accumulator stores, indirect stores and returns
// assumes one instruction word per cycle, held while busy_o is high
`timescale 1ns/1ps

// Notes on behaviour
// - bank literal loads bank register, flags kept
// - seven-bit literal loads program latch, flags kept
// - eight-bit literal loads accumulator in one cycle
// - accumulator stored to seven-bit file address
// - indirect store; relative offset leaves pointer
// - mode field picks pre/post inc/dec
// - indirect addresses redirect through pointer
// - sixteen-bit pointers wrap at both ends
// - pointer updates never change status flags
// - option load copies accumulator, flags kept
// - software reset resets device, clears flag
// - return pops stack, loads PC, two cycles
// - return sets global interrupt enable bit
module lmr_exec (
  input  wire logic                          clock_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          insn_valid_i,
  input  wire logic [lmr_pkg::INSN_W-1:0]    insn_i,
  input  wire logic [lmr_pkg::PC_W-1:0]      stack_top_i,
  output logic [lmr_pkg::DATA_W-1:0]         acc_o,
  output logic [lmr_pkg::BANK_W-1:0]         bank_select_reg_o,
  output logic [lmr_pkg::LATCH_W-1:0]        pc_upper_latch_o,
  output logic [lmr_pkg::DATA_W-1:0]         option_reg_o,
  output logic [lmr_pkg::DATA_W-1:0]         irq_control_reg_o,
  output logic                               global_irq_enable_o,
  output logic [lmr_pkg::PTR_W-1:0]          indirect_pointer0_o,
  output logic [lmr_pkg::PTR_W-1:0]          indirect_pointer1_o,
  output logic [lmr_pkg::PC_W-1:0]           pc_o,
  output logic                               stack_pop_o,
  output logic                               busy_o,
  output logic                               soft_reset_o,
  output logic                               soft_reset_flag_n_o,
  output lmr_pkg::lmr_wr_t                   mem_wr_o
);
  import lmr_pkg::*;

  // ==========================================================
  // decode
  function automatic logic hit(input logic [INSN_W-1:0] w, input logic [INSN_W-1:0] op,
                               input logic [INSN_W-1:0] m);
    hit = ((w & m) == op);
  endfunction

  lmr_state_t              state_ff, nxt_state;
  wire logic               run       = (state_ff == ST_RUN) && insn_valid_i;
  wire logic               is_nop    = run && hit(insn_i, OP_NOP, MSK_ALL);
  wire logic               is_reset  = run && hit(insn_i, OP_RESET, MSK_ALL);
  wire logic               is_reti   = run && hit(insn_i, OP_RETI, MSK_ALL);
  wire logic               is_opt    = run && hit(insn_i, OP_OPT, MSK_ALL);
  wire logic               is_stiw   = run && hit(insn_i, OP_STIW, MSK_STIW);
  wire logic               is_stf    = run && hit(insn_i, OP_STF, MSK_F7);
  wire logic               is_ldb    = run && hit(insn_i, OP_LDB, MSK_B5);
  wire logic               is_stik   = run && hit(insn_i, OP_STIK, MSK_F7);
  wire logic               is_ldp    = run && hit(insn_i, OP_LDP, MSK_K7);
  // the latch load sits inside the accumulator literal space
  wire logic               is_ldw    = run && hit(insn_i, OP_LDW, MSK_K8) && !is_ldp;
  wire logic [FADDR_W-1:0] faddr     = insn_i[FADDR_W-1:0];
  wire logic [OFFS_W-1:0]  koff      = insn_i[OFFS_W-1:0];
  wire logic               sel_ptr   = is_stik ? insn_i[OFFS_W] : insn_i[SEL_BIT];
  wire lmr_mode_t          mode      = lmr_mode_t'(insn_i[MODE_W-1:0]);

  // ==========================================================
  // indirect address generation
  logic [PTR_W-1:0] ptr_ff [2];
  logic [PTR_W-1:0] nxt_ptr [2];
  wire logic [PTR_W-1:0] cur_ptr = ptr_ff[sel_ptr];
  wire logic [PTR_W-1:0] ptr_inc = cur_ptr + PTR_ONE;
  wire logic [PTR_W-1:0] ptr_dec = cur_ptr - PTR_ONE;
  wire logic [PTR_W-1:0] ptr_rel = cur_ptr + {{(PTR_W-OFFS_W){koff[OFFS_W-1]}}, koff};
  wire logic [PTR_W-1:0] mode_ea = (mode == MODE_PREINC) ? ptr_inc :
                                   (mode == MODE_PREDEC) ? ptr_dec : cur_ptr;
  wire logic [PTR_W-1:0] mode_np = (mode == MODE_PREINC || mode == MODE_POSTINC) ? ptr_inc
                                   : ptr_dec;
  // direct store to an indirect port goes through its pointer
  wire logic             stf_ind = (faddr == IND0_ADDR) || (faddr == IND1_ADDR);
  wire logic [PTR_W-1:0] stf_ea  = (faddr == IND1_ADDR) ? ptr_ff[1] : ptr_ff[0];

  lmr_wr_t nxt_wr;
  always_comb begin
    nxt_wr = '0;
    if (is_stf) begin
      nxt_wr.en       = 1'b1;
      nxt_wr.indirect = stf_ind;
      nxt_wr.addr     = stf_ind ? stf_ea : {{(PTR_W-FADDR_W){1'b0}}, faddr};
      nxt_wr.data     = acc_o;
    end else if (is_stiw || is_stik) begin
      nxt_wr.en       = 1'b1;
      nxt_wr.indirect = 1'b1;
      nxt_wr.addr     = is_stik ? ptr_rel : mode_ea;
      nxt_wr.data     = acc_o;
    end
  end

  // pointer write back; relative mode leaves pointer alone
  generate
    for (genvar g = 0; g < 2; g++) begin : g_ptr
      always_comb begin
        nxt_ptr[g] = ptr_ff[g];
        if (is_stiw && (sel_ptr == 1'(g))) begin
          nxt_ptr[g] = mode_np;
        end
      end
      always_ff @(posedge clock_i) begin
        if (!rst_n_i || state_ff == ST_RESET) begin
          ptr_ff[g] <= PTR_RST;
        end else begin
          ptr_ff[g] <= nxt_ptr[g];
        end
      end
    end
  endgenerate

  // ==========================================================
  // sequencing
  logic [PC_W-1:0] pc_ff;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (is_reset) begin
          nxt_state = ST_RESET;
        end else if (is_reti) begin
          nxt_state = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        nxt_state = ST_RUN;
      end
      ST_RESET: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // unknown words still advance the PC so the core never hangs
  wire logic [PC_W-1:0] nxt_pc = is_reti ? stack_top_i :
                                 run ? pc_ff + PC_ONE : pc_ff;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_ff            <= ST_RUN;
      soft_reset_flag_n_o <= 1'b1;
    end else begin
      state_ff            <= nxt_state;
      if (is_reset) begin
        soft_reset_flag_n_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // architectural registers
  // software reset returns everything except the reset flag to its reset value
  wire logic clr = !rst_n_i || (state_ff == ST_RESET);

  always_ff @(posedge clock_i) begin
    if (clr) begin
      acc_o <= ACC_RST;
    end else if (is_ldw) begin
      acc_o <= insn_i[DATA_W-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (clr) begin
      bank_select_reg_o <= '0;
    end else if (is_ldb) begin
      bank_select_reg_o <= insn_i[BANK_W-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (clr) begin
      pc_upper_latch_o <= '0;
    end else if (is_ldp) begin
      pc_upper_latch_o <= insn_i[LATCH_W-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (clr) begin
      option_reg_o <= OPT_RST;
    end else if (is_opt) begin
      option_reg_o <= acc_o;
    end
  end

  always_ff @(posedge clock_i) begin
    if (clr) begin
      irq_control_reg_o <= INTC_RST;
    end else if (is_reti) begin
      irq_control_reg_o[GIE_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (clr) begin
      pc_ff <= '0;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // one-cycle pulses and the busy window of two-cycle instructions
  always_ff @(posedge clock_i) begin
    if (clr) begin
      stack_pop_o  <= 1'b0;
      busy_o       <= 1'b0;
      soft_reset_o <= 1'b0;
    end else begin
      stack_pop_o  <= is_reti;
      busy_o       <= (nxt_state != ST_RUN);
      soft_reset_o <= is_reset;
    end
  end

  always_ff @(posedge clock_i) begin
    if (clr) begin
      mem_wr_o <= '0;
    end else begin
      mem_wr_o <= nxt_wr;
    end
  end

  assign pc_o                = pc_ff;
  assign global_irq_enable_o = irq_control_reg_o[GIE_BIT];
  assign indirect_pointer0_o = ptr_ff[0];
  assign indirect_pointer1_o = ptr_ff[1];
endmodule

// ===== lmr_exec_monitor.sv
// checker for the literal, move and return execution block
// assumes lmr_pkg is compiled first; bound onto every lmr_exec
`timescale 1ns/1ps
module lmr_exec_monitor (
  input wire logic                     clock_i,
  input wire logic                     rst_n_i,
  input wire logic                     insn_valid_i,
  input wire logic [13:0]              insn_i,
  input wire logic [14:0]              stack_top_i,
  input wire logic [7:0]               acc_o,
  input wire logic [7:0]               option_reg_o,
  input wire logic [7:0]               irq_control_reg_o,
  input wire logic [4:0]               bank_select_reg_o,
  input wire logic [6:0]               pc_upper_latch_o,
  input wire logic [15:0]              indirect_pointer0_o,
  input wire logic [15:0]              indirect_pointer1_o,
  input wire logic [14:0]              pc_o,
  input wire logic                     global_irq_enable_o,
  input wire logic                     stack_pop_o,
  input wire logic                     busy_o,
  input wire logic                     soft_reset_o,
  input wire logic                     soft_reset_flag_n_o,
  input wire lmr_pkg::lmr_wr_t         mem_wr_o
);
  import lmr_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  wire logic take = insn_valid_i && !busy_o;
  function automatic logic hit(input logic [13:0] m, input logic [13:0] o);
    return take && ((insn_i & m) == o);
  endfunction
  // ==========================================
  // assertions
  ldb_load_a: assert property (hit(MSK_B5, OP_LDB) |=>
    bank_select_reg_o == $past(insn_i[4:0])) else $error("bank load wrong");
  ldp_load_a: assert property (hit(MSK_K7, OP_LDP) |=>
    pc_upper_latch_o == $past(insn_i[6:0])) else $error("latch load wrong");
  ldw_load_a: assert property (hit(MSK_K8, OP_LDW) && !hit(MSK_K7, OP_LDP) |=>
    acc_o == $past(insn_i[7:0])) else $error("acc load wrong");
  stf_write_a: assert property (hit(MSK_F7, OP_STF) && insn_i[6:1] != 6'h00 |=>
    mem_wr_o.en && mem_wr_o.addr == {9'h000, $past(insn_i[6:0])} && mem_wr_o.data == $past(acc_o))
    else $error("file store wrong");
  rel_keep_a: assert property (hit(MSK_K7, OP_STIK) |=> mem_wr_o.en &&
    $stable(indirect_pointer0_o) && $stable(indirect_pointer1_o)) else $error("relative store wrong");
  reti_seq_a: assert property (hit(MSK_ALL, OP_RETI) |=> pc_o == $past(stack_top_i) &&
    global_irq_enable_o && stack_pop_o && busy_o ##1 !busy_o) else $error("return sequence wrong");
  nop_step_a: assert property (hit(MSK_ALL, OP_NOP) |=>
    pc_o == $past(pc_o) + PC_ONE && $stable(acc_o)) else $error("nop changed state");
  srst_flag_a: assert property (hit(MSK_ALL, OP_RESET) |=>
    soft_reset_o ##[0:1] !soft_reset_flag_n_o) else $error("soft reset wrong");
  opt_load_a: assert property (hit(MSK_ALL, OP_OPT) |=>
    option_reg_o == $past(acc_o)) else $error("option load wrong");
  ptr_step_a: assert property (hit(MSK_STIW, OP_STIW) && !insn_i[2] |=>
    indirect_pointer0_o == ($past(insn_i[0]) ? $past(indirect_pointer0_o) - PTR_ONE
    : $past(indirect_pointer0_o) + PTR_ONE)) else $error("pointer update wrong");
  stf_redirect_a: assert property (hit(MSK_F7, OP_STF) && insn_i[6:0] == 7'h01 |=>
    mem_wr_o.en && mem_wr_o.indirect && mem_wr_o.addr == indirect_pointer1_o)
    else $error("indirect port store wrong");
  pc_step_a: assert property (take && !hit(MSK_ALL, OP_RETI) && !hit(MSK_ALL, OP_RESET) |=>
    pc_o == $past(pc_o) + PC_ONE) else $error("pc step wrong");
  cover property (hit(MSK_STIW, OP_STIW));
  cover property (hit(MSK_ALL, OP_RETI));
  cover property (hit(MSK_K7, OP_STIK));
  cover property (hit(MSK_ALL, OP_RESET));
endmodule
bind lmr_exec lmr_exec_monitor i_lmr_exec_monitor (.clock_i, .rst_n_i, .insn_valid_i, .insn_i,
  .stack_top_i, .acc_o, .option_reg_o, .irq_control_reg_o, .bank_select_reg_o,
  .pc_upper_latch_o, .indirect_pointer0_o,
  .indirect_pointer1_o, .pc_o, .global_irq_enable_o, .stack_pop_o, .busy_o, .soft_reset_o,
  .soft_reset_flag_n_o, .mem_wr_o);

// ===== lmr_exec_tb_top.sv
// testbench for the literal, move and return execution block
// assumes lmr_pkg, lmr_exec and its checker are compiled first
`timescale 1ns/1ps
module lmr_exec_tb_top;
  import lmr_pkg::*;
  typedef struct packed {
    logic [13:0] insn;
    logic [2:0]  sel;
    logic [24:0] exp;
  } lmr_row_t;
  logic clock_i = 1'b0, rst_n_i = 1'b0, insn_valid_i = 1'b0;
  logic [13:0] insn_i = 14'h0000;
  logic [14:0] stack_top_i = 15'h1234, pc_o, pc_exp;
  logic [7:0] acc_o, option_reg_o, irq_control_reg_o;
  logic [4:0] bank_select_reg_o;
  logic [6:0] pc_upper_latch_o;
  logic [15:0] indirect_pointer0_o, indirect_pointer1_o;
  logic global_irq_enable_o, stack_pop_o, busy_o, soft_reset_o, soft_reset_flag_n_o;
  lmr_wr_t mem_wr_o;
  int n_errors = 0;
  int tests_run = 0;
  lmr_row_t rows [16] = '{
    '{14'h305A, 3'h0, 25'h000005A},
    '{14'h003F, 3'h1, 25'h000001F},
    '{14'h31FF, 3'h2, 25'h000007F},
    '{14'h0062, 3'h3, 25'h000005A},
    '{14'h0018, 3'h6, 25'h100015A},
    '{14'h0019, 3'h6, 25'h100005A},
    '{14'h0019, 3'h6, 25'h1FFFF5A},
    '{14'h001A, 3'h4, 25'h0000000},
    '{14'h001F, 3'h5, 25'h000FFFF},
    '{14'h3FE0, 3'h6, 25'h1FFDF5A},
    '{14'h00A5, 3'h6, 25'h100255A},
    '{14'h0081, 3'h6, 25'h1FFFF5A},
    '{14'h3F85, 3'h6, 25'h100055A},
    '{14'h00A5, 3'h7, 25'h0000002},
    '{14'h0080, 3'h7, 25'h0000003},
    '{14'h0000, 3'h0, 25'h000005A}};
  lmr_exec i_lmr_exec (.clock_i, .rst_n_i, .insn_valid_i, .insn_i, .stack_top_i, .acc_o,
    .bank_select_reg_o, .pc_upper_latch_o, .option_reg_o, .irq_control_reg_o,
    .global_irq_enable_o, .indirect_pointer0_o, .indirect_pointer1_o, .pc_o, .stack_pop_o,
    .busy_o, .soft_reset_o, .soft_reset_flag_n_o, .mem_wr_o);
  always #5 clock_i = ~clock_i;
  function automatic logic [24:0] got(input logic [2:0] s);
    case (s)
      3'h0: return {17'h00000, acc_o};
      3'h1: return {20'h00000, bank_select_reg_o};
      3'h2: return {18'h00000, pc_upper_latch_o};
      3'h3: return {17'h00000, option_reg_o};
      3'h4: return {9'h000, indirect_pointer0_o};
      3'h5: return {9'h000, indirect_pointer1_o};
      3'h7: return {23'h0, mem_wr_o.en, mem_wr_o.indirect};
      default: return {mem_wr_o.en, mem_wr_o.addr, mem_wr_o.data};
    endcase
  endfunction
  task automatic chk(input string nm, input logic [24:0] e, input logic [24:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic exec(input logic [13:0] w);
    @(posedge clock_i); #1;
    insn_i = w;
    insn_valid_i = 1'b1;
    @(posedge clock_i); #1;
    insn_valid_i = 1'b0;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    chk("reset state", {ACC_RST, OPT_RST, 3'h4, 6'h00}, {acc_o, option_reg_o,
      soft_reset_flag_n_o, global_irq_enable_o, busy_o, pc_o[5:0]});
    chk("reset pc", 25'h0, {10'h000, pc_o});
    chk("reset outputs", 25'h0, {10'h000, bank_select_reg_o, pc_upper_latch_o, stack_pop_o,
      soft_reset_o, mem_wr_o.en});
    pc_exp = 15'h0000;
    foreach (rows[i]) begin
      exec(rows[i].insn);
      pc_exp = pc_exp + PC_ONE;
      chk($sformatf("row %0d", i), rows[i].exp, got(rows[i].sel));
      chk("pc", {10'h000, pc_exp}, {10'h000, pc_o});
    end
    // a load offered while the return is busy must be dropped
    @(posedge clock_i); #1;
    insn_i = OP_RETI;
    insn_valid_i = 1'b1;
    @(posedge clock_i); #1;
    insn_i = 14'h3077;
    chk("return", {7'h00, 3'h7, 15'h1234}, {7'h00, global_irq_enable_o, stack_pop_o, busy_o, pc_o});
    chk("irq control bit", 25'h1, {24'h0, irq_control_reg_o[GIE_BIT]});
    @(posedge clock_i); #1;
    insn_valid_i = 1'b0;
    chk("busy drop", 25'h5A, {15'h0, stack_pop_o, busy_o, acc_o});
    exec(OP_RESET);
    chk("soft reset pulse", 25'h1, {24'h0, soft_reset_o});
    repeat (2) @(posedge clock_i);
    #1 chk("after soft reset", 25'h0, {soft_reset_flag_n_o, acc_o, 1'b0, pc_o});
    chk("soft reset regs", {OPT_RST, PTR_RST, 1'b0},
      {option_reg_o, indirect_pointer1_o, global_irq_enable_o});
    rst_n_i = 1'b0;
    repeat (2) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    chk("flag after reset", 25'h1, {24'h0, soft_reset_flag_n_o});
    report_and_stop();
  end
endmodule
